// [common/recl_pkg.sv]
package recl_pkg;

  // Register byte offsets
  localparam logic [7:0]  RECL_OFS_RESP_ADDR  = 8'h00;
  localparam logic [7:0]  RECL_OFS_SUMMARY    = 8'h04;
  localparam logic [7:0]  RECL_OFS_IRQ_MASK   = 8'h08;
  localparam int          RECL_PADDR_W        = 8;

  // Responder error address register layout
  localparam int          RECL_LEN_LSB        = 30;
  localparam int          RECL_LEN_W          = 2;
  localparam int          RECL_ADDR_LSB       = 0;
  localparam int          RECL_ADDR_W         = 30;

  // Module error summary register layout
  localparam int          RECL_BIT_CABLE_OK   = 31;
  localparam int          RECL_ID_LSB         = 20;
  localparam int          RECL_ID_W           = 6;
  localparam int          RECL_CMD_LSB        = 16;
  localparam int          RECL_CMD_W          = 4;
  localparam int          RECL_BIT_MULTI      = 14;
  localparam int          RECL_BIT_PMR_CORR   = 13;
  localparam int          RECL_BIT_PMR_UNCORR = 12;
  localparam int          RECL_BIT_INTERNAL   = 7;
  localparam int          RECL_BIT_IOWR_FAIL  = 6;
  localparam int          RECL_BIT_SUPPLY_LOW = 5;
  localparam int          RECL_BIT_RD_PARITY  = 0;

  // Index of each sticky error in the event vector
  localparam int          RECL_EV_RD_PARITY   = 0;
  localparam int          RECL_EV_IOWR_FAIL   = 1;
  localparam int          RECL_EV_INTERNAL    = 2;
  localparam int          RECL_EV_PMR_UNCORR  = 3;
  localparam int          RECL_EV_PMR_CORR    = 4;
  localparam int          RECL_EV_NUM         = 5;

  // Bits that may raise the interrupt; the mask register keeps only these
  localparam logic [31:0] RECL_IRQ_BITS       = 32'h0000_70c1;

  // Values after reset
  localparam logic [4:0]  RECL_RST_STICKY     = 5'h00;
  localparam logic [31:0] RECL_RST_MASK       = 32'h0000_0000;
  localparam logic        RECL_RST_FLAG       = 1'h0;
  localparam logic [31:0] RECL_RST_RDATA      = 32'h0000_0000;

endpackage : recl_pkg

// [core/recl_sync.sv]
`timescale 1ns/10ps
module recl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("recl_sync: width must be at least 1");
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : recl_sync

// [core/recl_capture_field.sv]
`timescale 1ns/10ps
module recl_capture_field #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Capture control
  input  wire logic         load,
  input  wire logic         locked,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] field_q;
  logic [W-1:0] field_d;

  if (W < 1) begin : g_bad_width
    $error("recl_capture_field: width must be at least 1");
  end

  // A held value survives later accepts until the lock drops
  assign field_d = (load && !locked) ? d : field_q;
  assign q       = field_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      field_q <= '0;
    end else begin
      field_q <= field_d;
    end
  end

endmodule : recl_capture_field

// [core/recl_error_log.sv]
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module recl_error_log
  import recl_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [RECL_PADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Responder side of the system bus
  input  wire logic                    caAccept,
  input  wire logic [31:0]             caData,
  input  wire logic [RECL_ID_W-1:0]    caNodeId,
  input  wire logic [RECL_CMD_W-1:0]   caCommand,
  // Error sources
  input  wire logic [RECL_EV_NUM-1:0]  errEvent,
  input  wire logic                    wseErr,
  input  wire logic                    ridnakErr,
  // Pins
  input  wire logic                    supplyLowPin,
  input  wire logic                    cablesOkPin,
  input  wire logic                    remotePoweredPin,
  // Interrupt
  output logic                         irq
);

  logic [RECL_LEN_W-1:0]  failLength;
  logic [RECL_ADDR_W-1:0] failAddress;
  logic [RECL_ID_W-1:0]   failNodeId;
  logic [RECL_CMD_W-1:0]  failCommand;
  logic [2:0]             pinSync;
  logic                   supplyLow;
  logic                   cablesOk;
  logic                   remotePowered;
  logic [4:0]             sticky_q;
  logic [4:0]             sticky_d;
  logic                   multi_q;
  logic                   multi_d;
  logic                   wsePrev_q;
  logic                   ridnakPrev_q;
  logic                   cableOk_q;
  logic                   cableOk_d;
  logic                   initDone_q;
  logic [1:0]             initWait_q;
  logic [31:0]            mask_q;
  logic [31:0]            mask_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   lockActive;
  logic                   pendingBefore;
  logic                   newError;
  logic                   cableFault;
  logic                   setupPhase;
  logic                   wrAccess;
  logic                   selAddr;
  logic                   selSummary;
  logic                   selMask;
  logic                   mapped;
  logic [31:0]            addrWord;
  logic [31:0]            summaryWord;
  logic [4:0]             stickyClear;
  logic                   multiClear;

  recl_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .asyncIn ({supplyLowPin, cablesOkPin, remotePoweredPin}),
    .syncOut (pinSync)
  );

  assign supplyLow     = pinSync[2];
  assign cablesOk      = pinSync[1];
  assign remotePowered = pinSync[0];

  // Lock sources; an errEvent in the accept cycle itself still lets that accept capture, a wseErr or ridnakErr there blocks it
  assign lockActive    = (|sticky_q) || wseErr || ridnakErr;
  assign pendingBefore = (|sticky_q) || wsePrev_q || ridnakPrev_q;
  // Supply-low and cable fault are not counted among the errors
  assign newError      = (|errEvent) || (wseErr && !wsePrev_q) ||
                         (ridnakErr && !ridnakPrev_q);

  recl_capture_field #(
    .W (RECL_LEN_W)
  ) u_len (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (caAccept),
    .locked  (lockActive),
    .d       (caData[RECL_LEN_LSB +: RECL_LEN_W]),
    .q       (failLength)
  );

  recl_capture_field #(
    .W (RECL_ADDR_W)
  ) u_addr (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (caAccept),
    .locked  (lockActive),
    .d       (caData[RECL_ADDR_LSB +: RECL_ADDR_W]),
    .q       (failAddress)
  );

  recl_capture_field #(
    .W (RECL_ID_W)
  ) u_id (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (caAccept),
    .locked  (lockActive),
    .d       (caNodeId),
    .q       (failNodeId)
  );

  recl_capture_field #(
    .W (RECL_CMD_W)
  ) u_cmd (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (caAccept),
    .locked  (lockActive),
    .d       (caCommand),
    .q       (failCommand)
  );

  // APB decode; the slave answers in the first access cycle
  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pwrite;
  assign selAddr    = (paddr == RECL_OFS_RESP_ADDR);
  assign selSummary = (paddr == RECL_OFS_SUMMARY);
  assign selMask    = (paddr == RECL_OFS_IRQ_MASK);
  assign mapped     = selAddr || selSummary || selMask;
  assign pready     = psel && penable;
  assign pslverr    = psel && penable && !mapped;

  // Write one to clear; an event in the same cycle wins
  assign stickyClear = (wrAccess && selSummary) ?
                       {pwdata[RECL_BIT_PMR_CORR], pwdata[RECL_BIT_PMR_UNCORR], pwdata[RECL_BIT_INTERNAL],
                        pwdata[RECL_BIT_IOWR_FAIL], pwdata[RECL_BIT_RD_PARITY]} : 5'h00;
  assign multiClear  = wrAccess && selSummary && pwdata[RECL_BIT_MULTI];
  assign sticky_d    = (sticky_q & ~stickyClear) | errEvent;
  assign multi_d     = (newError && pendingBefore) || (multi_q && !multiClear);

  // Cable state is sampled on each of the three init cycles, the last sample kept, then only a powered-but-unwired case clears it
  // Init lasts until the pin synchroniser holds real levels, not its reset zeros
  assign cableFault = remotePowered && !cablesOk;
  assign cableOk_d  = !initDone_q ? (cablesOk && remotePowered) :
                      (cableFault ? 1'b0 : cableOk_q);

  assign mask_d = (wrAccess && selMask) ? (pwdata & RECL_IRQ_BITS) : mask_q;

  assign addrWord = {failLength, failAddress};
  // Reserved fields are tied to zero here, so writes cannot reach them
  assign summaryWord = {cableOk_q, 5'h00, failNodeId, failCommand, 1'b0,
                        multi_q, sticky_q[RECL_EV_PMR_CORR], sticky_q[RECL_EV_PMR_UNCORR], 4'h0,
                        sticky_q[RECL_EV_INTERNAL], sticky_q[RECL_EV_IOWR_FAIL], supplyLow, 4'h0,
                        sticky_q[RECL_EV_RD_PARITY]};
  assign rdata_d = !setupPhase ? rdata_q :
                   selAddr     ? addrWord :
                   selSummary  ? summaryWord :
                   selMask     ? mask_q : RECL_RST_RDATA;
  assign prdata  = rdata_q;
  assign irq     = |(summaryWord & mask_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sticky_q     <= RECL_RST_STICKY;
      multi_q      <= RECL_RST_FLAG;
      wsePrev_q    <= RECL_RST_FLAG;
      ridnakPrev_q <= RECL_RST_FLAG;
      cableOk_q    <= RECL_RST_FLAG;
      initDone_q   <= RECL_RST_FLAG;
      initWait_q   <= {2{RECL_RST_FLAG}};
      mask_q       <= RECL_RST_MASK;
      rdata_q      <= RECL_RST_RDATA;
    end else begin
      sticky_q     <= sticky_d;
      multi_q      <= multi_d;
      wsePrev_q    <= wseErr;
      ridnakPrev_q <= ridnakErr;
      cableOk_q    <= cableOk_d;
      initWait_q   <= {initWait_q[0], 1'b1};
      initDone_q   <= initWait_q[1];
      mask_q       <= mask_d;
      rdata_q      <= rdata_d;
    end
  end

  // Checks
  sequence seq_open_accept;
    caAccept && !lockActive;
  endsequence

  sequence seq_held_accept;
    caAccept && lockActive;
  endsequence

  chk_len_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_open_accept |=> failLength == $past(caData[31:30]))
    else $error("failing length not taken on accept");

  chk_addr_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_open_accept |=> failAddress == $past(caData[29:0]))
    else $error("failing address not taken on accept");

  chk_lock_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_held_accept |=> $stable(addrWord))
    else $error("locked address word changed");

  chk_resume_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    lockActive ##1 seq_open_accept |=> failAddress == $past(caData[29:0]))
    else $error("capture did not resume after unlock");

  chk_id_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_open_accept |=> failNodeId == $past(caNodeId))
    else $error("failing node ID not taken on accept");

  chk_id_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_held_accept |=> $stable(failNodeId))
    else $error("locked node ID changed");

  chk_cmd_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_open_accept |=> failCommand == $past(caCommand))
    else $error("failing command not taken on accept");

  chk_cmd_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_held_accept |=> $stable(failCommand))
    else $error("locked command changed");

  chk_cable_init: assert property (@(posedge clk_sys) disable iff (!nrst)
    !initDone_q |=> cableOk_q == $past(cablesOk && remotePowered))
    else $error("cable-ok wrong after init");

  chk_cable_fault: assert property (@(posedge clk_sys) disable iff (!nrst)
    initDone_q && remotePowered && !cablesOk |=> !cableOk_q)
    else $error("cable-ok stayed set on cable fault");

  chk_multi_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|errEvent) && (|sticky_q) |=> multi_q ##1 (multi_q || $past(multiClear)))
    else $error("multi-error flag missed second error");

  chk_multi_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    !newError && !multi_q |=> !multi_q)
    else $error("multi-error flag set without error");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    summaryWord[30:26] == 5'h00 && summaryWord[15] == 1'b0)
    else $error("reserved summary bits not zero");

  chk_lock_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wseErr || ridnakErr || (|$past(errEvent))) |-> lockActive)
    else $error("error did not lock captures");

  chk_apb_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    psel && !penable ##1 psel && penable |-> pready)
    else $error("apb access not answered in first access cycle");

endmodule : recl_error_log

// [tb/recl_commander_model.sv]
`timescale 1ns/10ps
module recl_commander_model
  import recl_pkg::*;
(
  // Clock
  input  wire logic                  clk_sys,
  // Command/address cycle toward the responder
  output logic                       caAccept,
  output logic      [31:0]           caData,
  output logic      [RECL_ID_W-1:0]  caNodeId,
  output logic      [RECL_CMD_W-1:0] caCommand
);
  initial begin
    caAccept  = 1'b0;
    caData    = 32'h0000_0000;
    caNodeId  = 6'h00;
    caCommand = 4'h0;
  end

  // Lines are inverted after the cycle so a stale value can never pass for a capture
  task automatic accept(input logic [31:0] d, input logic [RECL_ID_W-1:0] id, input logic [RECL_CMD_W-1:0] cmd);
    @(posedge clk_sys);
    caAccept  <= 1'b1;
    caData    <= d;
    caNodeId  <= id;
    caCommand <= cmd;
    @(posedge clk_sys);
    caAccept  <= 1'b0;
    caData    <= ~d;
    caNodeId  <= ~id;
    caCommand <= ~cmd;
  endtask : accept
endmodule : recl_commander_model

// [tb/tb_responder_error_capture_log.sv]
`timescale 1ns/10ps
module tb_responder_error_capture_log
  import recl_pkg::*;
;
  localparam logic [5:0]  ID  = 6'h2a;
  localparam logic [3:0]  CMD = 4'h9;
  localparam logic [31:0] CAB = 32'h8000_0000;
  localparam logic [31:0] FLD = (32'(ID) << RECL_ID_LSB) | (32'(CMD) << RECL_CMD_LSB);
  localparam logic [7:0]  RA  = RECL_OFS_RESP_ADDR;
  localparam logic [7:0]  RS  = RECL_OFS_SUMMARY;
  logic        clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, caData;
  logic        pready, pslverr, irq, caAccept;
  logic [5:0]  caNodeId;
  logic [3:0]  caCommand;
  logic [4:0]  errEvent = 5'h00;
  logic        wseErr = 1'b0, ridnakErr = 1'b0, supplyLowPin = 1'b0, cablesOkPin = 1'b1, remotePoweredPin = 1'b1;
  int          fails = 0, n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  recl_error_log recl_error_log_i (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .caAccept(caAccept),
    .caData(caData), .caNodeId(caNodeId), .caCommand(caCommand), .errEvent(errEvent), .wseErr(wseErr),
    .ridnakErr(ridnakErr), .supplyLowPin(supplyLowPin), .cablesOkPin(cablesOkPin),
    .remotePoweredPin(remotePoweredPin), .irq(irq));
  recl_commander_model recl_commander_model_i (.clk_sys(clk_sys), .caAccept(caAccept), .caData(caData),
    .caNodeId(caNodeId), .caCommand(caCommand));

  function automatic logic [31:0] bitv(input int n);
    return 32'h0000_0001 << n;
  endfunction : bitv

  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int i;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      fails++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr = 1'b0);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk($sformatf("read %h", a), exp, r);
    chk($sformatf("error %h", a), {31'h0, eerr}, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic acc(input logic [31:0] d, input logic [5:0] id, input logic [3:0] cmd);
    recl_commander_model_i.accept(d, id, cmd);
  endtask : acc

  task automatic pulse(input int k);
    @(posedge clk_sys);
    errEvent <= 5'h01 << k;
    @(posedge clk_sys);
    errEvent <= 5'h00;
  endtask : pulse

  task automatic s_reset();
    rd(RA, 32'h0000_0000);
    rd(RS, CAB);
    rd(RECL_OFS_IRQ_MASK, RECL_RST_MASK);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : s_reset

  task automatic s_capture();
    acc(32'h4000_0001, 6'h15, 4'h6);
    acc(32'hb234_5678, ID, CMD);
    rd(RA, 32'hb234_5678);
    rd(RS, CAB | FLD);
  endtask : s_capture

  task automatic s_lock_multi();
    pulse(RECL_EV_IOWR_FAIL);
    acc(32'h1234_0000, 6'h01, 4'h1);
    rd(RA, 32'hb234_5678);
    pulse(RECL_EV_RD_PARITY);
    rd(RS, CAB | FLD | bitv(RECL_BIT_MULTI) | bitv(RECL_BIT_IOWR_FAIL) | bitv(RECL_BIT_RD_PARITY));
    wr(RS, 32'hffff_ffff);
    rd(RS, CAB | FLD);
    acc(32'h1234_0000, ID, CMD);
    rd(RA, 32'h1234_0000);
    wr(RA, 32'hffff_ffff);
    rd(RA, 32'h1234_0000);
    rd(8'h0c, 32'h0000_0000, 1'b1);
  endtask : s_lock_multi

  task automatic s_lock_sources();
    for (int k = 0; k < 7; k++) begin
      acc(32'h2000_0000 + k, ID, CMD);
      if (k < 5)
        pulse(k);
      else if (k == 5)
        wseErr <= 1'b1;
      else
        ridnakErr <= 1'b1;
      acc(32'h3fff_ffff, 6'h3f, 4'hf);
      rd(RA, 32'h2000_0000 + k);
      wseErr    <= 1'b0;
      ridnakErr <= 1'b0;
      wr(RS, 32'hffff_ffff);
      acc(32'h2000_0100 + k, ID, CMD);
      rd(RA, 32'h2000_0100 + k);
    end
  endtask : s_lock_sources

  task automatic s_supply_irq();
    pulse(RECL_EV_INTERNAL);
    supplyLowPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(RS, CAB | FLD | bitv(RECL_BIT_INTERNAL) | bitv(RECL_BIT_SUPPLY_LOW));
    wr(RECL_OFS_IRQ_MASK, 32'hffff_ffff);
    rd(RECL_OFS_IRQ_MASK, RECL_IRQ_BITS);
    @(negedge clk_sys);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(RECL_OFS_IRQ_MASK, 32'h0000_0000);
    @(negedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(RECL_OFS_IRQ_MASK, 32'hffff_ffff);
    wr(RS, bitv(RECL_BIT_INTERNAL));
    @(negedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(RS, CAB | FLD | bitv(RECL_BIT_SUPPLY_LOW));
  endtask : s_supply_irq

  task automatic s_cable();
    cablesOkPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(RS, FLD | bitv(RECL_BIT_SUPPLY_LOW));
    cablesOkPin  <= 1'b1;
    supplyLowPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(RS, FLD);
  endtask : s_cable

  task automatic s_reinit();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(RA, 32'h0000_0000);
    rd(RS, CAB);
    chk("irq after reset", 32'h0, {31'h0, irq});
  endtask : s_reinit

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    s_reset();
    s_capture();
    s_lock_multi();
    s_lock_sources();
    s_supply_irq();
    s_cable();
    s_reinit();
    give_verdict();
  end
endmodule : tb_responder_error_capture_log
